// File: ecp_defines.vh
// Register offsets, field positions and widths for the page-2 control group.
// Included by every design file of the preload control block.
`ifndef ECP_DEFINES_VH
`define ECP_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets (5-bit address within the page)
// ----------------------------------------------------------------------
`define ECP_ADDR_W          5
`define ECP_OFF_PATTERN     5'h11
`define ECP_OFF_TRIGGER     5'h12
`define ECP_OFF_LOADCTRL    5'h15
`define ECP_OFF_BER_PRE     5'h18
`define ECP_OFF_RAI_PRE     5'h19
`define ECP_OFF_FAE_PRE     5'h1a
`define ECP_OFF_BPV_PRE_HI  5'h1c
`define ECP_OFF_BPV_PRE_LO  5'h1d
`define ECP_OFF_EBIT_PRE    5'h1e
`define ECP_OFF_CRC_PRE     5'h1f

// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define ECP_RST_BYTE        8'h00
`define ECP_RST_WORD        16'h0000
`define ECP_ONE_BYTE        8'h01
`define ECP_ONE_WORD        16'h0001
`define ECP_ZERO_BYTE       8'h00
`define ECP_LOADCTRL_MASK   8'h3f
`define ECP_BIT_B0_MISS     7
`define ECP_BIT_B0_MATCH    6
`define ECP_BIT_B1_MISS     5
`define ECP_BIT_B1_MATCH    4
`define ECP_BIT_E0_MISS     3
`define ECP_BIT_E0_MATCH    2
`define ECP_BIT_E1_MISS     1
`define ECP_BIT_E1_MATCH    0
`define ECP_LD_CRC          5
`define ECP_LD_EBIT         4
`define ECP_LD_BPV          3
`define ECP_LD_FAE          2
`define ECP_LD_RAI          1
`define ECP_LD_BER          0

`endif

// File: ecp_counter.v
// Preloadable wrapping event counter for one performance counter.
// Assumes the load strobe and increment are synchronous to mclk.
`timescale 1ns/1ps
`include "ecp_defines.vh"

module ecp_counter #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             mclk,
    input  wire             reset,
    // Control
    input  wire             loadEn,
    input  wire [WIDTH-1:0] loadValue,
    input  wire             countEn,
    // Status
    output reg  [WIDTH-1:0] count_r,
    output reg              wrap_r
);

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // Load wins over increment so a preload is never bumped the same cycle
    always @(posedge mclk) begin
        if (reset) begin
            count_r <= {WIDTH{1'b0}};
            wrap_r  <= 1'b0;
        end else if (loadEn) begin
            count_r <= loadValue;
            wrap_r  <= 1'b0;
        end else if (countEn) begin
            count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
            wrap_r  <= &count_r;
        end else begin
            wrap_r  <= 1'b0;
        end
    end

endmodule

// File: ecp_preload_ctrl.v
// Page-2 control group: BER pattern compare, circular buffer start/stop
// triggers and preload of six performance counters.
// Assumes a simple synchronous host port and event inputs on mclk.
`timescale 1ns/1ps
`include "ecp_defines.vh"

module ecp_preload_ctrl #(
    parameter BPV_WIDTH = 16
) (
    // Clock and reset
    input  wire                  mclk,
    input  wire                  reset,
    input  wire                  softReset,
    // Host register port
    input  wire [4:0]            hostAddr,
    input  wire                  hostWrite,
    input  wire                  hostRead,
    input  wire [7:0]            hostWrData,
    output reg  [7:0]            hostRdData_r,
    // Mode
    input  wire                  serialBackplaneMode,
    // Receive compare inputs
    input  wire                  buf1DataValid,
    input  wire [7:0]            buf1Data,
    input  wire                  codeDetectValid,
    input  wire                  codeDetectMatch,
    // Error events from the receive path
    input  wire                  raiCrcEvent,
    input  wire                  frameAlignErrEvent,
    input  wire                  bipolarViolEvent,
    input  wire                  ebitErrEvent,
    input  wire                  crc4ErrEvent,
    // Circular buffer accumulate state
    output reg                   buf0Accumulate_r,
    output reg                   buf1Accumulate_r,
    // Counter values and overflow pulses
    output wire [7:0]            bitErrorRateCount,
    output wire [7:0]            raiCrcCount,
    output wire [7:0]            frameAlignErrCount,
    output wire [BPV_WIDTH-1:0]  bipolarViolCount,
    output wire [7:0]            ebitErrCount,
    output wire [7:0]            crc4ErrCount,
    output wire [5:0]            counterWrap
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg  [7:0] berPatternBits_r;
    reg  [7:0] trigCtrl_r;
    reg  [7:0] loadCtrl_r;
    reg  [7:0] berPreloadValue_r;
    reg  [7:0] raiCrcPreloadValue_r;
    reg  [7:0] frameAlignErrPreloadValue_r;
    reg  [7:0] bpvPreloadHi_r;
    reg  [7:0] bpvPreloadLo_r;
    reg  [7:0] ebitPreloadValue_r;
    reg  [7:0] crc4PreloadValue_r;
    reg  [7:0] loadCtrlPrev_r;
    reg  [7:0] berMissCount_r;
    reg        berCountEn_r;

    wire       ctrlReset = reset | softReset;
    wire [5:0] loadStrobe;
    wire [7:0] mismatchBits;
    reg  [7:0] readMux;

    // Control bits default to zero; soft reset acts like reset here
    always @(posedge mclk) begin
        if (ctrlReset) begin
            berPatternBits_r <= `ECP_RST_BYTE;
            trigCtrl_r       <= `ECP_RST_BYTE;
            loadCtrl_r       <= `ECP_RST_BYTE;
        end else if (hostWrite) begin
            case (hostAddr)
                `ECP_OFF_PATTERN:  berPatternBits_r <= hostWrData;
                `ECP_OFF_TRIGGER:  trigCtrl_r       <= hostWrData;
                `ECP_OFF_LOADCTRL: loadCtrl_r       <= hostWrData
                                                     & `ECP_LOADCTRL_MASK;
                default: ;
            endcase
        end
    end

    // Preload words have no documented reset; zero keeps simulation clean.
    // Writing them steers no counter by itself.
    always @(posedge mclk) begin
        if (reset) begin
            berPreloadValue_r           <= `ECP_RST_BYTE;
            raiCrcPreloadValue_r        <= `ECP_RST_BYTE;
            frameAlignErrPreloadValue_r <= `ECP_RST_BYTE;
            bpvPreloadHi_r              <= `ECP_RST_BYTE;
            bpvPreloadLo_r              <= `ECP_RST_BYTE;
            ebitPreloadValue_r          <= `ECP_RST_BYTE;
            crc4PreloadValue_r          <= `ECP_RST_BYTE;
        end else if (hostWrite) begin
            case (hostAddr)
                `ECP_OFF_BER_PRE:    berPreloadValue_r <= hostWrData;
                `ECP_OFF_RAI_PRE:    raiCrcPreloadValue_r <= hostWrData;
                `ECP_OFF_FAE_PRE:
                    frameAlignErrPreloadValue_r <= hostWrData;
                `ECP_OFF_BPV_PRE_HI: bpvPreloadHi_r <= hostWrData;
                `ECP_OFF_BPV_PRE_LO: bpvPreloadLo_r <= hostWrData;
                `ECP_OFF_EBIT_PRE:   ebitPreloadValue_r <= hostWrData;
                `ECP_OFF_CRC_PRE:    crc4PreloadValue_r <= hostWrData;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Load edge detection
    // ------------------------------------------------------------------
    // Previous copy tracks the bit even outside the backplane mode, so a
    // bit already high when the mode turns on does not fire a late load
    always @(posedge mclk) begin
        if (ctrlReset) begin
            loadCtrlPrev_r <= `ECP_RST_BYTE;
        end else begin
            loadCtrlPrev_r <= loadCtrl_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : gLoad
            assign loadStrobe[gi] = loadCtrl_r[gi] & ~loadCtrlPrev_r[gi]
                                  & serialBackplaneMode;
        end
    endgenerate

    // ------------------------------------------------------------------
    // BER compare
    // ------------------------------------------------------------------
    assign mismatchBits = buf1Data ^ berPatternBits_r;

    // Population count of mismatching bits in the received byte
    integer bi;
    reg [7:0] missSum;
    always @* begin
        missSum = `ECP_ZERO_BYTE;
        for (bi = 0; bi < 8; bi = bi + 1) begin
            missSum = missSum + {7'h00, mismatchBits[bi]};
        end
    end

    // Mismatches are applied to the counter one per cycle; a new byte
    // arriving before the last is drained adds to the backlog
    always @(posedge mclk) begin
        if (reset) begin
            berMissCount_r <= `ECP_ZERO_BYTE;
            berCountEn_r   <= 1'b0;
        end else begin
            // Enable follows the decrement, so each mismatch counts once
            berCountEn_r <= (berMissCount_r != `ECP_ZERO_BYTE);
            if (buf1DataValid) begin
                berMissCount_r <= berMissCount_r + missSum
                    - ((berMissCount_r != `ECP_ZERO_BYTE) ?
                       `ECP_ONE_BYTE : `ECP_ZERO_BYTE);
            end else if (berMissCount_r != `ECP_ZERO_BYTE) begin
                berMissCount_r <= berMissCount_r - `ECP_ONE_BYTE;
            end
        end
    end

    // ------------------------------------------------------------------
    // Circular buffer triggers
    // ------------------------------------------------------------------
    wire hitMiss  = codeDetectValid & ~codeDetectMatch;
    wire hitMatch = codeDetectValid &  codeDetectMatch;

    wire start0 = (trigCtrl_r[`ECP_BIT_B0_MISS]  & hitMiss)
                | (trigCtrl_r[`ECP_BIT_B0_MATCH] & hitMatch);
    wire buf1_begin_trigger = (trigCtrl_r[`ECP_BIT_B1_MISS]  & hitMiss)
                | (trigCtrl_r[`ECP_BIT_B1_MATCH] & hitMatch);
    wire buf0_end_trigger  = (trigCtrl_r[`ECP_BIT_E0_MISS]  & hitMiss)
                | (trigCtrl_r[`ECP_BIT_E0_MATCH] & hitMatch);
    wire buf1_end_trigger  = (trigCtrl_r[`ECP_BIT_E1_MISS]  & hitMiss)
                | (trigCtrl_r[`ECP_BIT_E1_MATCH] & hitMatch);

    // Stop wins if both fire on one word: safer to freeze the capture
    always @(posedge mclk) begin
        if (ctrlReset) begin
            buf0Accumulate_r <= 1'b0;
            buf1Accumulate_r <= 1'b0;
        end else begin
            if (buf0_end_trigger) begin
                buf0Accumulate_r <= 1'b0;
            end else if (start0) begin
                buf0Accumulate_r <= 1'b1;
            end
            if (buf1_end_trigger) begin
                buf1Accumulate_r <= 1'b0;
            end else if (buf1_begin_trigger) begin
                buf1Accumulate_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------------
    ecp_counter #(.WIDTH(8)) uBer (
        .mclk      (mclk),
        .reset     (reset),
        .loadEn    (loadStrobe[`ECP_LD_BER]),
        .loadValue (berPreloadValue_r),
        .countEn   (berCountEn_r),
        .count_r   (bitErrorRateCount),
        .wrap_r    (counterWrap[`ECP_LD_BER])
    );
    ecp_counter #(.WIDTH(8)) uRai (
        .mclk      (mclk),
        .reset     (reset),
        .loadEn    (loadStrobe[`ECP_LD_RAI]),
        .loadValue (raiCrcPreloadValue_r),
        .countEn   (raiCrcEvent),
        .count_r   (raiCrcCount),
        .wrap_r    (counterWrap[`ECP_LD_RAI])
    );
    ecp_counter #(.WIDTH(8)) uFae (
        .mclk      (mclk),
        .reset     (reset),
        .loadEn    (loadStrobe[`ECP_LD_FAE]),
        .loadValue (frameAlignErrPreloadValue_r),
        .countEn   (frameAlignErrEvent),
        .count_r   (frameAlignErrCount),
        .wrap_r    (counterWrap[`ECP_LD_FAE])
    );
    ecp_counter #(.WIDTH(BPV_WIDTH)) uBpv (
        .mclk      (mclk),
        .reset     (reset),
        .loadEn    (loadStrobe[`ECP_LD_BPV]),
        .loadValue ({bpvPreloadHi_r, bpvPreloadLo_r}),
        .countEn   (bipolarViolEvent),
        .count_r   (bipolarViolCount),
        .wrap_r    (counterWrap[`ECP_LD_BPV])
    );
    ecp_counter #(.WIDTH(8)) uEbit (
        .mclk      (mclk),
        .reset     (reset),
        .loadEn    (loadStrobe[`ECP_LD_EBIT]),
        .loadValue (ebitPreloadValue_r),
        .countEn   (ebitErrEvent),
        .count_r   (ebitErrCount),
        .wrap_r    (counterWrap[`ECP_LD_EBIT])
    );
    ecp_counter #(.WIDTH(8)) uCrc (
        .mclk      (mclk),
        .reset     (reset),
        .loadEn    (loadStrobe[`ECP_LD_CRC]),
        .loadValue (crc4PreloadValue_r),
        .countEn   (crc4ErrEvent),
        .count_r   (crc4ErrCount),
        .wrap_r    (counterWrap[`ECP_LD_CRC])
    );

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Unmapped offsets read zero
    always @* begin
        case (hostAddr)
            `ECP_OFF_PATTERN:    readMux = berPatternBits_r;
            `ECP_OFF_TRIGGER:    readMux = trigCtrl_r;
            `ECP_OFF_LOADCTRL:   readMux = loadCtrl_r;
            `ECP_OFF_BER_PRE:    readMux = berPreloadValue_r;
            `ECP_OFF_RAI_PRE:    readMux = raiCrcPreloadValue_r;
            `ECP_OFF_FAE_PRE:    readMux = frameAlignErrPreloadValue_r;
            `ECP_OFF_BPV_PRE_HI: readMux = bpvPreloadHi_r;
            `ECP_OFF_BPV_PRE_LO: readMux = bpvPreloadLo_r;
            `ECP_OFF_EBIT_PRE:   readMux = ebitPreloadValue_r;
            `ECP_OFF_CRC_PRE:    readMux = crc4PreloadValue_r;
            default:             readMux = `ECP_ZERO_BYTE;
        endcase
    end

    always @(posedge mclk) begin
        if (reset) begin
            hostRdData_r <= `ECP_ZERO_BYTE;
        end else if (hostRead) begin
            hostRdData_r <= readMux;
        end
    end

endmodule

// File: ecp_preload_ctrl_properties.sv
// Concurrent checks for the page-2 preload control block.
// Assumes it is bound to ecp_preload_ctrl and sees only its ports.
`timescale 1ns/1ps

module ecp_props_chk (
    // Clock and reset
    input logic       mclk,
    input logic       reset,
    input logic       softReset,
    // Host port
    input logic [4:0] hostAddr,
    input logic       hostWrite,
    input logic       hostRead,
    input logic [7:0] hostWrData,
    input logic [7:0] hostRdData_r,
    // Mode and receive inputs
    input logic       serialBackplaneMode,
    input logic       codeDetectValid,
    input logic       crc4ErrEvent,
    // Observed state
    input logic       buf0Accumulate_r,
    input logic       buf1Accumulate_r,
    input logic [7:0] bitErrorRateCount,
    input logic [7:0] crc4ErrCount,
    input logic [5:0] counterWrap
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // Shadow of the BER preload, so a load can be checked by value
    logic [7:0] berPre_r;
    always_ff @(posedge mclk) begin
        if (reset)
            berPre_r <= 8'h00;
        else if (hostWrite && hostAddr == 5'h18)
            berPre_r <= hostWrData;
    end

    // Clear then set of the BER load bit, one idle cycle between
    sequence s_clr_ber;
        hostWrite && hostAddr == 5'h15 && !hostWrData[0];
    endsequence
    sequence s_set_ber;
        !(hostWrite && hostAddr == 5'h15) ##1
        (hostWrite && hostAddr == 5'h15 && hostWrData[0]);
    endsequence

    property p_ber_load;
        s_clr_ber ##1 s_set_ber ##1 (serialBackplaneMode && !softReset &&
            !(hostWrite && hostAddr == 5'h18))
            |=> bitErrorRateCount == berPre_r;
    endproperty
    a_ber_load: assert property (p_ber_load)
        else $error("BER counter not loaded from preload");

    property p_rd_hold;
        !hostRead && !softReset |=> $stable(hostRdData_r);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data changed without a read");

    property p_rd_unmapped;
        hostRead && hostAddr == 5'h13 |=> hostRdData_r == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not zero");

    property p_ld_unused;
        hostRead && hostAddr == 5'h15 |=> hostRdData_r[7:6] == 2'b00;
    endproperty
    a_ld_unused: assert property (p_ld_unused)
        else $error("unused load bits read nonzero");

    property p_crc_wrap;
        counterWrap[5] |-> crc4ErrCount == 8'h00 &&
            $past(crc4ErrCount) == 8'hff;
    endproperty
    a_crc_wrap: assert property (p_crc_wrap)
        else $error("CRC wrap flag without all-ones to zero");

    property p_ber_wrap;
        counterWrap[0] |-> bitErrorRateCount == 8'h00 &&
            $past(bitErrorRateCount) == 8'hff;
    endproperty
    a_ber_wrap: assert property (p_ber_wrap)
        else $error("BER wrap flag without all-ones to zero");

    property p_crc_inc;
        crc4ErrEvent && !serialBackplaneMode
            |=> crc4ErrCount == $past(crc4ErrCount) + 8'h01;
    endproperty
    a_crc_inc: assert property (p_crc_inc)
        else $error("CRC counter did not advance by one");

    property p_crc_hold;
        !crc4ErrEvent && !serialBackplaneMode |=> $stable(crc4ErrCount);
    endproperty
    a_crc_hold: assert property (p_crc_hold)
        else $error("CRC counter changed with no event");

    property p_acc_hold;
        !codeDetectValid && !softReset
            |=> $stable(buf0Accumulate_r) && $stable(buf1Accumulate_r);
    endproperty
    a_acc_hold: assert property (p_acc_hold)
        else $error("accumulate flag moved without a compare");
endmodule

bind ecp_preload_ctrl ecp_props_chk ecp_props_chk_i (.mclk, .reset,
    .softReset, .hostAddr, .hostWrite, .hostRead, .hostWrData,
    .hostRdData_r, .serialBackplaneMode, .codeDetectValid, .crc4ErrEvent,
    .buf0Accumulate_r, .buf1Accumulate_r, .bitErrorRateCount,
    .crc4ErrCount, .counterWrap);

// File: ecp_tb.sv
// Self-checking bench for the page-2 preload control block.
// Assumes the host port and counter timing of ecp_preload_ctrl.
`timescale 1ns/1ps

module tb;
    logic        mclk, reset, softReset, hostWrite, hostRead, mode;
    logic [4:0]  hostAddr;
    logic [7:0]  hostWrData, hostRdData_r, buf1Data;
    logic        buf1DataValid, codeDetectValid, codeDetectMatch, crcEv;
    logic [3:0]  evs;
    logic        buf0Accumulate_r, buf1Accumulate_r, b, m;
    logic [7:0]  berCnt, raiCnt, faeCnt, ebitCnt, crcCnt;
    logic [15:0] bpvCnt;
    logic [5:0]  counterWrap;
    logic [4:0]  preAddr [0:5] = '{5'h18, 5'h19, 5'h1a, 5'h1c, 5'h1e, 5'h1f};
    int          mismatches, n_checks;

    ecp_preload_ctrl #(.BPV_WIDTH(16)) ecp_preload_ctrl_i (.mclk, .reset,
        .softReset, .hostAddr, .hostWrite, .hostRead, .hostWrData,
        .hostRdData_r, .serialBackplaneMode(mode), .buf1DataValid,
        .buf1Data, .codeDetectValid, .codeDetectMatch,
        .raiCrcEvent(evs[0]), .frameAlignErrEvent(evs[1]),
        .bipolarViolEvent(evs[2]), .ebitErrEvent(evs[3]), .crc4ErrEvent(crcEv),
        .buf0Accumulate_r, .buf1Accumulate_r, .bitErrorRateCount(berCnt),
        .raiCrcCount(raiCnt), .frameAlignErrCount(faeCnt),
        .bipolarViolCount(bpvCnt), .ebitErrCount(ebitCnt),
        .crc4ErrCount(crcCnt), .counterWrap);

    // -----------------------------------------------------------------
    // Clock, helpers and bus tasks
    // -----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Inputs move 1 ns after the edge, never on it
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Each access leaves an idle edge, so strobes never toggle twice
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        tick(1);
        hostAddr = a;
        hostWrData = d;
        hostWrite = 1'b1;
        tick(1);
        hostWrite = 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        tick(1);
        hostAddr = a;
        hostRead = 1'b1;
        tick(1);
        hostRead = 1'b0;
        chk("read data", {8'h00, hostRdData_r}, {8'h00, e});
    endtask

    task automatic code_detect_pattern(input logic mt);
        tick(1);
        codeDetectValid = 1'b1;
        codeDetectMatch = mt;
        tick(1);
        codeDetectValid = 1'b0;
        tick(1);
    endtask

    task automatic load(input logic [7:0] bits);
        wr(5'h15, 8'h00);
        wr(5'h15, bits);
        tick(3);
    endtask

    function automatic logic [15:0] cntOf(input int k);
        case (k)
            0: return {8'h00, berCnt};
            1: return {8'h00, raiCnt};
            2: return {8'h00, faeCnt};
            3: return bpvCnt;
            4: return {8'h00, ebitCnt};
            default: return {8'h00, crcCnt};
        endcase
    endfunction

    // Accumulate flag of buffer one when sel is high, else buffer zero
    function automatic logic accOf(input logic sel);
        return sel ? buf1Accumulate_r : buf0Accumulate_r;
    endfunction

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard: the whole run needs well under this many cycles
    initial begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        close_out();
    end

    // -----------------------------------------------------------------
    // Test sequence
    // -----------------------------------------------------------------
    initial begin
        {reset, mode} = 2'b11;
        {softReset, hostWrite, hostRead, crcEv} = 4'h0;
        evs = 4'h0;
        {buf1DataValid, codeDetectValid, codeDetectMatch} = 3'h0;
        {hostAddr, hostWrData, buf1Data} = 21'h0;
        mismatches = 0;
        n_checks = 0;
        tick(3);
        reset = 1'b0;
        rd(5'h11, 8'h00);
        rd(5'h12, 8'h00);
        rd(5'h15, 8'h00);
        rd(5'h13, 8'h00);
        wr(5'h11, 8'ha5);
        rd(5'h11, 8'ha5);
        wr(5'h15, 8'hff);
        rd(5'h15, 8'h3f);
        $display("test registers done");
        for (int k = 0; k < 6; k++) begin
            wr(preAddr[k], 8'(48 + k));
            if (k == 3)
                wr(5'h1d, 8'hc3);
            tick(3);
            chk("count before load", cntOf(k), 16'h0000);
            load(8'(1 << k));
            case (k)
                0: chk("ber loaded", cntOf(0), 16'h0030);
                1: chk("rai loaded", cntOf(1), 16'h0031);
                2: chk("fae loaded", cntOf(2), 16'h0032);
                3: chk("bpv loaded", cntOf(3), 16'h33c3);
                4: chk("ebit loaded", cntOf(4), 16'h0034);
                default: chk("crc loaded", cntOf(5), 16'h0035);
            endcase
        end
        // One event on each of the four evs counters (RAI, FAE, BPV, E-bit) must step it from its preload
        evs = 4'hf;
        tick(1);
        evs = 4'h0;
        chk("rai counts on", cntOf(1), 16'h0032);
        chk("fae counts on", cntOf(2), 16'h0033);
        chk("bpv counts on", cntOf(3), 16'h33c4);
        chk("ebit counts on", cntOf(4), 16'h0035);
        $display("test preload done");
        mode = 1'b0;
        wr(5'h1f, 8'hff);
        load(8'h20);
        chk("load with mode low", cntOf(5), 16'h0035);
        mode = 1'b1;
        wr(5'h15, 8'h20);
        tick(3);
        chk("load on level", cntOf(5), 16'h0035);
        load(8'h20);
        chk("crc loaded", cntOf(5), 16'h00ff);
        mode = 1'b0;
        crcEv = 1'b1;
        tick(1);
        crcEv = 1'b0;
        chk("crc wrapped", cntOf(5), 16'h0000);
        chk("crc wrap flag", {15'h0, counterWrap[5]}, 16'h0001);
        tick(1);
        crcEv = 1'b1;
        tick(1);
        crcEv = 1'b0;
        chk("crc counts on", cntOf(5), 16'h0001);
        mode = 1'b1;
        $display("test mode and wrap done");
        wr(5'h11, 8'h0f);
        wr(5'h18, 8'hff);
        load(8'h01);
        for (int j = 0; j < 2; j++) begin
            buf1Data = j == 0 ? 8'h0e : 8'h3c;
            buf1DataValid = 1'b1;
            tick(1);
            buf1DataValid = 1'b0;
            tick(8);
        end
        chk("bit error count", cntOf(0), 16'h0004);
        $display("test compare done");
        for (int i = 0; i < 8; i++) begin
            b = (i % 4) < 2;
            m = (i % 2) == 0;
            if (i >= 4)
                wr(5'h12, 8'(1 << i));
            else
                wr(5'h12, 8'(1 << i) | 8'(1 << ((b ? 4 : 6) + m)));
            code_detect_pattern(!m);
            chk("word one", accOf(b), i < 4);
            code_detect_pattern(m);
            chk("word two", accOf(b), i >= 4);
            chk("other buf", accOf(!b), 1'b0);
            softReset = 1'b1;
            tick(1);
            softReset = 1'b0;
        end
        rd(5'h11, 8'h00);
        $display("test triggers done");
        close_out();
    end
endmodule
